// File: core/tsp_port.sv
// timed serdes io port: clock blocks, counter, serializer and pin drive
`timescale 1ns/100ps
// How it works
// - port width parameter: 1, 4, 8, 16 or 32 pins
// - whole port is input or output
// - drive pins or sample, optionally on condition
// - register access completes in one cycle
// - open collector: zero pulls low, one releases
// - open collector chosen per port
// - serializer plus transfer register carry data
// - 16-bit counter times the transfer
// - counter readable, transfers deferred to counter value
// - counter captured as timestamp per transfer
// - enabled link takes shared pins away
// - narrower port claim overrides this port
// - unclaimed pins stay with this port
// - port always transfers at its full width
// - six clock blocks, block zero reference 100MHz
// - clock block may divide external pin clock
// - incoming strobe qualifies input, outgoing strobe output
// - reset attaches port to clock block zero
// - pin events signalled without polling
// - pull-downs enabled while in reset
module tsp_port #(
  parameter int unsigned PORT_W = 4
) (
  // clock and reset
  input  wire logic                      ref_clk_i,
  input  wire logic                      rst_i,
  // register port
  input  wire tsp_pkg::tsp_req_t         req_i,
  output logic [tsp_pkg::DATA_W-1:0]     rdata_o,
  // pins
  input  wire logic [PORT_W-1:0]         pin_in_i,
  output logic [PORT_W-1:0]              pin_out_o,
  output logic [PORT_W-1:0]              pin_oe_n_o,
  output logic [PORT_W-1:0]              pull_dn_o,
  input  wire logic                      ext_clk_i,
  // strobes
  input  wire logic                      incoming_strobe_i,
  output logic                           outgoing_strobe_o,
  // pin sharing, from the tile
  input  wire logic                      link_en_i,
  input  wire logic [PORT_W-1:0]         narrow_claim_i,
  // event to the tile scheduler
  output logic                           event_o
);
  import tsp_pkg::*;

  localparam int unsigned SHIFTS = XFER_W / PORT_W;
  localparam int unsigned SC_W   = (SHIFTS > 1) ? $clog2(SHIFTS) : 1;
  localparam logic [SC_W-1:0] LAST_SHIFT = SC_W'(SHIFTS - 1);

  // ************************************************************
  // registers and nets
  // ************************************************************
  tsp_ctrl_t             ctrl_ff;
  logic [PORT_W-1:0]     cond_ff;
  logic [CNT_W-1:0]      time_ff;
  logic [CNT_W-1:0]      cnt_ff;
  logic [CNT_W-1:0]      ts_ff;
  logic [XFER_W-1:0]     xfer_ff;
  logic                  tx_full_ff;
  logic                  rx_full_ff;
  logic [XFER_W-1:0]     sh_ff;
  logic [SC_W-1:0]       sc_ff;
  tsp_state_t            state_ff;
  tsp_state_t            nxt_state;
  logic [PORT_W-1:0]     pin_s1_ff;
  logic [PORT_W-1:0]     pin_s2_ff;
  logic                  strb_s1_ff;
  logic                  strb_s2_ff;
  logic                  ext_s1_ff;
  logic                  ext_s2_ff;
  logic                  ext_s3_ff;
  logic [REF_CNT_W-1:0]  ref_cnt_ff;
  logic [NUM_CB-1:0]     cb_tick;
  tsp_cb_t               cb_rd [NUM_CB];
  logic [PORT_W-1:0]     pout_ff;
  logic [PORT_W-1:0]     pad_out_ff;
  logic [PORT_W-1:0]     pad_oe_n_ff;
  logic [PORT_W-1:0]     pd_ff;
  logic [DATA_W-1:0]     rdata_ff;
  logic                  event_ff;
  logic                  ostrb_ff;
  logic                  tick;
  logic                  ext_rise;
  logic                  hit;
  logic                  strb_ok;
  logic                  go_sh;
  logic                  take_tx;
  logic                  rx_done;
  logic                  cond_met;
  logic [XFER_W-1:0]     in_shift;
  logic [PORT_W-1:0]     avail;
  logic [PORT_W-1:0]     drive_en;

  // register decode, used by both write and read paths
  function automatic logic f_sel(input tsp_req_t r, input logic [ADDR_W-1:0] a);
    f_sel = (r.addr == a);
  endfunction : f_sel

  // ************************************************************
  // synchronisers for pins, strobe and external clock
  // ************************************************************
  // external levels pass two flops before any logic reads them
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_s1_ff  <= '0;
      pin_s2_ff  <= '0;
      strb_s1_ff <= 1'b0;
      strb_s2_ff <= 1'b0;
      ext_s1_ff  <= 1'b0;
      ext_s2_ff  <= 1'b0;
      ext_s3_ff  <= 1'b0;
    end else begin
      pin_s1_ff  <= pin_in_i;
      pin_s2_ff  <= pin_s1_ff;
      strb_s1_ff <= incoming_strobe_i;
      strb_s2_ff <= strb_s1_ff;
      ext_s1_ff  <= ext_clk_i;
      ext_s2_ff  <= ext_s1_ff;
      ext_s3_ff  <= ext_s2_ff;
    end
  end

  // edge seen only past the second flop
  assign ext_rise = ext_s2_ff & ~ext_s3_ff;

  // ************************************************************
  // clock blocks
  // ************************************************************
  // block zero is the reference: one tick per REF_DIV system cycles
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ref_cnt_ff <= '0;
    end else if (ref_cnt_ff == REF_DIV_M1) begin
      ref_cnt_ff <= '0;
    end else begin
      ref_cnt_ff <= ref_cnt_ff + 1'b1;
    end
  end
  assign cb_tick[0] = (ref_cnt_ff == REF_DIV_M1);
  assign cb_rd[0]   = CB_RST;

  // blocks above zero: source is reference or pin edge, then a divider
  for (genvar i = 1; i < NUM_CB; i++) begin : g_cb
    tsp_cb_t             cfg_ff;
    logic [CB_DIV_W-1:0] dcnt_ff;
    logic                src;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
        cfg_ff <= CB_RST;
      end else if (req_i.wr && f_sel(req_i, A_CB1 + ADDR_W'(i - 1))) begin
        cfg_ff <= tsp_cb_t'(req_i.wdata[CB_W-1:0]);
      end
    end

    assign src = cfg_ff.ext ? ext_rise : cb_tick[0];

    // divide by div+1 source edges; zero passes every edge
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
        dcnt_ff <= '0;
      end else if (src) begin
        dcnt_ff <= (dcnt_ff >= cfg_ff.div) ? '0 : dcnt_ff + 1'b1;
      end
    end

    assign cb_tick[i] = src & (dcnt_ff >= cfg_ff.div);
    assign cb_rd[i]   = cfg_ff;
  end

  // out-of-range selections give no tick rather than aliasing a block
  assign tick = (ctrl_ff.cb_sel < CB_SEL_W'(NUM_CB)) ? cb_tick[ctrl_ff.cb_sel] : 1'b0;

  // ************************************************************
  // control registers
  // ************************************************************
  // reset selects clock block zero via the all-zero control value
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_ff <= CTRL_RST;
      cond_ff <= '0;
      time_ff <= '0;
    end else if (req_i.wr) begin
      if (f_sel(req_i, A_CTRL)) begin
        ctrl_ff <= tsp_ctrl_t'(req_i.wdata[CTRL_W-1:0]);
      end
      if (f_sel(req_i, A_COND)) begin
        cond_ff <= req_i.wdata[PORT_W-1:0];
      end
      if (f_sel(req_i, A_TIME)) begin
        time_ff <= req_i.wdata[CNT_W-1:0];
      end
    end
  end

  // ************************************************************
  // port counter
  // ************************************************************
  // natural overflow gives the wrap back to zero
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff <= '0;
    end else if (tick) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // ************************************************************
  // transfer sequencer
  // ************************************************************
  always_comb begin
    hit       = (ctrl_ff.cond == COND_EQ) ? (pin_s2_ff == cond_ff)
                                          : (pin_s2_ff != cond_ff);
    strb_ok   = ~ctrl_ff.strb_en | strb_s2_ff;
    go_sh     = (state_ff == S_SHIFT) & tick & (ctrl_ff.dir_out | strb_ok);
    in_shift  = XFER_W'({pin_s2_ff, sh_ff} >> PORT_W);
    nxt_state = state_ff;
    take_tx   = 1'b0;
    rx_done   = 1'b0;
    cond_met  = 1'b0;
    case (state_ff)
      S_IDLE: begin
        if (ctrl_ff.dir_out && tx_full_ff) begin
          nxt_state = ctrl_ff.timed ? S_WAIT_TIME : S_SHIFT;
          take_tx   = ~ctrl_ff.timed;
        end else if (!ctrl_ff.dir_out && !rx_full_ff) begin
          if (ctrl_ff.cond != COND_NONE) begin
            nxt_state = S_WAIT_COND;
          end else begin
            nxt_state = ctrl_ff.timed ? S_WAIT_TIME : S_SHIFT;
          end
        end
      end
      S_WAIT_COND: begin
        if (tick && hit) begin
          cond_met  = 1'b1;
          nxt_state = ctrl_ff.timed ? S_WAIT_TIME : S_SHIFT;
        end
      end
      S_WAIT_TIME: begin
        if (tick && cnt_ff == time_ff) begin
          nxt_state = S_SHIFT;
          take_tx   = ctrl_ff.dir_out;
        end
      end
      S_SHIFT: begin
        if (go_sh && sc_ff == LAST_SHIFT) begin
          nxt_state = S_IDLE;
          rx_done   = ~ctrl_ff.dir_out;
        end
      end
      default: begin
        nxt_state = S_IDLE;
      end
    endcase
    // disabling aborts whatever was in flight
    if (!ctrl_ff.en) begin
      nxt_state = S_IDLE;
      take_tx   = 1'b0;
      rx_done   = 1'b0;
      cond_met  = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= S_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // serializer: a full word moves as SHIFTS slices of the port width
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sh_ff   <= '0;
      sc_ff   <= '0;
      pout_ff <= '0;
    end else if (take_tx) begin
      sh_ff <= xfer_ff;
      sc_ff <= '0;
    end else if (nxt_state == S_SHIFT && state_ff != S_SHIFT) begin
      sc_ff <= '0;
    end else if (go_sh) begin
      sc_ff <= sc_ff + 1'b1;
      if (ctrl_ff.dir_out) begin
        pout_ff <= sh_ff[PORT_W-1:0];
        sh_ff   <= sh_ff >> PORT_W;
      end else begin
        sh_ff <= in_shift;
      end
    end
  end

  // timestamp, event and strobe pulses
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ts_ff    <= '0;
      event_ff <= 1'b0;
      ostrb_ff <= 1'b0;
    end else begin
      if (take_tx || rx_done) begin
        ts_ff <= cnt_ff;
      end
      event_ff <= cond_met | rx_done;
      ostrb_ff <= go_sh & ctrl_ff.dir_out & ctrl_ff.strb_en;
    end
  end

  // ************************************************************
  // transfer register
  // ************************************************************
  // hardware set beats a same-cycle software clear so no word is lost
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      xfer_ff    <= '0;
      tx_full_ff <= 1'b0;
      rx_full_ff <= 1'b0;
    end else begin
      if (rx_done) begin
        xfer_ff <= in_shift;
      end else if (req_i.wr && f_sel(req_i, A_DATA) && ctrl_ff.dir_out) begin
        xfer_ff <= req_i.wdata[XFER_W-1:0];
      end
      if (req_i.wr && f_sel(req_i, A_DATA) && ctrl_ff.dir_out) begin
        tx_full_ff <= 1'b1;
      end else if (take_tx || !ctrl_ff.en) begin
        tx_full_ff <= 1'b0;
      end
      if (rx_done) begin
        rx_full_ff <= 1'b1;
      end else if (req_i.rd && f_sel(req_i, A_DATA)) begin
        rx_full_ff <= 1'b0;
      end
    end
  end

  // ************************************************************
  // pin drive and sharing
  // ************************************************************
  // a link or a narrower port takes a pin; the rest stay ours
  assign avail = ~narrow_claim_i & ~{PORT_W{link_en_i}};

  // open collector only ever drives zero; a one floats the pin
  assign drive_en = {PORT_W{ctrl_ff.en & ctrl_ff.dir_out}} & avail
                  & ~({PORT_W{ctrl_ff.oc}} & pout_ff);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pad_out_ff  <= '0;
      pad_oe_n_ff <= '1;
    end else begin
      pad_out_ff  <= ctrl_ff.oc ? '0 : pout_ff;
      pad_oe_n_ff <= ~drive_en;
    end
  end

  // pull-downs held on through reset, dropped at the first edge after
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pd_ff <= '1;
    end else begin
      pd_ff <= '0;
    end
  end

  // ************************************************************
  // register read
  // ************************************************************
  // single-cycle answer; data stands one cycle only, unmapped reads zero
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= '0;
      if (req_i.rd) begin
        if (f_sel(req_i, A_CTRL)) rdata_ff <= DATA_W'(ctrl_ff);
        if (f_sel(req_i, A_DATA)) rdata_ff <= DATA_W'(xfer_ff);
        if (f_sel(req_i, A_COND)) rdata_ff <= DATA_W'(cond_ff);
        if (f_sel(req_i, A_TIME)) rdata_ff <= DATA_W'(time_ff);
        if (f_sel(req_i, A_CNT)) rdata_ff <= DATA_W'(cnt_ff);
        if (f_sel(req_i, A_TSTAMP)) rdata_ff <= DATA_W'(ts_ff);
        if (f_sel(req_i, A_STAT)) begin
          rdata_ff[ST_RX_FULL] <= rx_full_ff;
          rdata_ff[ST_TX_FULL] <= tx_full_ff;
          rdata_ff[ST_BUSY]    <= (state_ff != S_IDLE);
        end
        for (int k = 1; k < NUM_CB; k++) begin
          if (f_sel(req_i, A_CB1 + ADDR_W'(k - 1))) rdata_ff <= DATA_W'(cb_rd[k]);
        end
      end
    end
  end

  assign rdata_o           = rdata_ff;
  assign pin_out_o         = pad_out_ff;
  assign pin_oe_n_o        = pad_oe_n_ff;
  assign pull_dn_o         = pd_ff;
  assign outgoing_strobe_o = ostrb_ff;
  assign event_o           = event_ff;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb_chk @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  property p_width;
    (PORT_W == 1) || (PORT_W == 4) || (PORT_W == 8) || (PORT_W == 16) || (PORT_W == 32);
  endproperty
  a_width: assert property (p_width) else $error("port width not supported");

  property p_cnt_step;
    tick |=> cnt_ff == $past(cnt_ff) + 16'h0001;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("counter did not step");

  property p_ref_rate;
    cb_tick[0] |=> !cb_tick[0] ##1 cb_tick[0];
  endproperty
  a_ref_rate: assert property (p_ref_rate) else $error("reference tick rate wrong");

  property p_oc_low;
    ctrl_ff.oc && $past(ctrl_ff.oc) |-> pad_out_ff == '0;
  endproperty
  a_oc_low: assert property (p_oc_low) else $error("open collector drove high");

  property p_in_float;
    !ctrl_ff.dir_out [*2] |-> pad_oe_n_ff == '1;
  endproperty
  a_in_float: assert property (p_in_float) else $error("input port drives pins");

  property p_link_off;
    link_en_i |=> pad_oe_n_ff == '1;
  endproperty
  a_link_off: assert property (p_link_off) else $error("link pins still driven");

  property p_claim_off;
    narrow_claim_i[0] |=> pad_oe_n_ff[0];
  endproperty
  a_claim_off: assert property (p_claim_off) else $error("claimed pin still driven");

  property p_stamp;
    rx_done |=> ts_ff == $past(cnt_ff) && rx_full_ff && event_o;
  endproperty
  a_stamp: assert property (p_stamp) else $error("timestamp or flag missed");

  property p_cnt_read;
    req_i.rd && req_i.addr == A_CNT |=> rdata_o == DATA_W'($past(cnt_ff));
  endproperty
  a_cnt_read: assert property (p_cnt_read) else $error("counter read wrong");

  property p_cond_evt;
    state_ff == S_WAIT_COND && tick && hit && ctrl_ff.en |=> event_o ##1 !event_o;
  endproperty
  a_cond_evt: assert property (p_cond_evt) else $error("condition event missing");

endmodule : tsp_port

// File: core/tsp_pkg.sv
// shared constants, register map and types for the timed serdes io port
package tsp_pkg;

  // ************************************************************
  // widths and clocking
  // ************************************************************
  localparam int unsigned ADDR_W    = 4;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned XFER_W    = 32;
  localparam int unsigned CNT_W     = 16;
  localparam int unsigned NUM_CB    = 6;
  localparam int unsigned CB_SEL_W  = 3;
  localparam int unsigned CB_DIV_W  = 8;
  localparam int unsigned CLK_MHZ   = 200;
  localparam int unsigned REF_MHZ   = 100;
  localparam int unsigned REF_CNT_W = 4;
  // system clock cycles per reference tick, less one
  localparam logic [REF_CNT_W-1:0] REF_DIV_M1 = REF_CNT_W'(CLK_MHZ / REF_MHZ - 1);

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [ADDR_W-1:0] A_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] A_DATA   = 4'h1;
  localparam logic [ADDR_W-1:0] A_COND   = 4'h2;
  localparam logic [ADDR_W-1:0] A_TIME   = 4'h3;
  localparam logic [ADDR_W-1:0] A_CNT    = 4'h4;
  localparam logic [ADDR_W-1:0] A_TSTAMP = 4'h5;
  localparam logic [ADDR_W-1:0] A_STAT   = 4'h6;
  localparam logic [ADDR_W-1:0] A_CB1    = 4'h8;

  // status bit positions
  localparam int unsigned ST_RX_FULL = 0;
  localparam int unsigned ST_TX_FULL = 1;
  localparam int unsigned ST_BUSY    = 2;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {COND_NONE, COND_EQ, COND_NEQ} tsp_cond_t;

  typedef struct packed {
    logic [CB_SEL_W-1:0] cb_sel;
    logic                strb_en;
    logic                timed;
    tsp_cond_t           cond;
    logic                oc;
    logic                dir_out;
    logic                en;
  } tsp_ctrl_t;
  localparam int unsigned CTRL_W   = $bits(tsp_ctrl_t);
  localparam tsp_ctrl_t   CTRL_RST = '0;

  typedef struct packed {
    logic                ext;
    logic [CB_DIV_W-1:0] div;
  } tsp_cb_t;
  localparam int unsigned CB_W   = $bits(tsp_cb_t);
  localparam tsp_cb_t     CB_RST = '0;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } tsp_req_t;

  typedef enum {S_IDLE, S_WAIT_COND, S_WAIT_TIME, S_SHIFT} tsp_state_t;

endpackage : tsp_pkg

// File: tb/tsp_app_model.sv
// application-side model of the hardware wired to the port pins
`timescale 1ns/100ps
module tsp_app_model #(
  parameter int unsigned PORT_W = 4
) (
  // pins seen from the board
  input  wire logic [PORT_W-1:0] pin_out_i,
  input  wire logic [PORT_W-1:0] pin_oe_n_i,
  input  wire logic [PORT_W-1:0] app_val_i,
  output logic [PORT_W-1:0]      pin_in_o,
  // pin clock and strobe
  input  wire logic              ext_run_i,
  input  wire logic              strobe_i,
  output logic                   ext_clk_o,
  output logic                   incoming_strobe_o
);
  // ************************************************************
  // pin levels
  // ************************************************************
  // the port's level where it drives, the board's level where it lets go
  always_comb begin
    for (int k = 0; k < PORT_W; k++) begin
      pin_in_o[k] = pin_oe_n_i[k] ? app_val_i[k] : pin_out_i[k];
    end
  end

  // strobe qualifying the data the board offers
  assign incoming_strobe_o = strobe_i;

  // ************************************************************
  // board clock
  // ************************************************************
  // stands low when stopped; odd 17 ns half-period keeps it unrelated to the core clock
  initial begin
    ext_clk_o = 1'b0;
    forever begin
      #17;
      if (ext_run_i || ext_clk_o) ext_clk_o = ~ext_clk_o;
    end
  end
endmodule : tsp_app_model

// File: tb/tb_timed_serdes_io_port.sv
// self-checking bench for the timed serdes io port
`timescale 1ns/100ps
module tb_timed_serdes_io_port;
  import tsp_pkg::*;
  localparam int unsigned W = 4;
  logic              ref_clk, rst, link_en, ext_run, in_strb, ext_clk, inc_strb;
  logic              out_strb, event_w, ok;
  tsp_req_t          req;
  logic [DATA_W-1:0] rdata, got, c0;
  logic [W-1:0]      pin_in, pin_out, oe_n, pull_dn, claim, app_val, p_out, p_oe;
  logic [W-1:0]      outq[$];
  logic [W-1:0]      oeq[$];
  int                mismatches, tests_run, cycles, n_ev, n_strb;

  tsp_port #(.PORT_W(W)) i_dut (
    .ref_clk_i(ref_clk), .rst_i(rst), .req_i(req), .rdata_o(rdata),
    .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_n_o(oe_n), .pull_dn_o(pull_dn),
    .ext_clk_i(ext_clk), .incoming_strobe_i(inc_strb), .outgoing_strobe_o(out_strb),
    .link_en_i(link_en), .narrow_claim_i(claim), .event_o(event_w));

  tsp_app_model #(.PORT_W(W)) i_app (
    .pin_out_i(pin_out), .pin_oe_n_i(oe_n), .app_val_i(app_val), .pin_in_o(pin_in),
    .ext_run_i(ext_run), .strobe_i(in_strb), .ext_clk_o(ext_clk),
    .incoming_strobe_o(inc_strb));

  // ************************************************************
  // clock, watchers and timeout
  // ************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // log pin changes and pulses; a hang ends the run as a failure
  always @(posedge ref_clk) begin
    cycles++;
    if (event_w === 1'b1) n_ev++;
    if (out_strb === 1'b1) n_strb++;
    if (pin_out !== p_out) outq.push_back(pin_out);
    if (oe_n !== p_oe) oeq.push_back(oe_n);
    p_out = pin_out;
    p_oe = oe_n;
    if (cycles == 6000) begin
      mismatches++;
      test_done();
    end
  end

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    req <= '0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge ref_clk);
    req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    req <= '0;
    #1 got = rdata;
  endtask : rd

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wait_cyc

  task automatic test_done();
    if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done

  // ************************************************************
  // sequence
  // ************************************************************
  initial begin
    rst = 1'b1;
    req = '0;
    link_en = 1'b0;
    ext_run = 1'b0;
    in_strb = 1'b1;
    claim = '0;
    app_val = '0;
    wait_cyc(6);
    chk(32'(pull_dn), 32'hF, "pull-downs in reset");
    chk(32'(oe_n), 32'hF, "pins released in reset");
    wait_cyc(6);
    rst <= 1'b0;
    wait_cyc(2);
    chk(32'(pull_dn), 32'h0, "pull-downs after reset");
    rd(A_CTRL);
    chk(got, 32'h0, "ctrl reset");
    rd(4'hF);
    chk(got, 32'h0, "unmapped read");
    // two counter reads nine edges apart, block zero ticking every second edge
    rd(A_CNT);
    c0 = got;
    wait_cyc(7);
    rd(A_CNT);
    chk(got - c0, 32'h5, "tick rate");
    // untimed output with strobes, lowest slice first
    wr(A_CTRL, 32'h43);
    outq.delete();
    n_strb = 0;
    wr(A_DATA, 32'h8765_4321);
    wait_cyc(60);
    chk(32'(outq.size()), 32'h8, "slice count");
    foreach (outq[k]) chk(32'(outq[k]), 32'(k + 1), "slice order");
    chk(32'(n_strb), 32'h8, "outgoing strobes");
    chk(32'(oe_n), 32'h0, "whole port drives");
    // open collector: zeros driven low, ones released
    wr(A_CTRL, 32'h47);
    wait_cyc(4);
    oeq.delete();
    wr(A_DATA, 32'hA5A5_A5A5);
    wait_cyc(60);
    chk(32'(oe_n), 32'hA, "open collector release");
    chk(32'(pin_out), 32'h0, "open collector level");
    chk(32'(oeq.size() >= 7), 32'h1, "open collector slices");
    // link owns every pin
    wr(A_CTRL, 32'h03);
    link_en <= 1'b1;
    ok = 1'b1;
    wr(A_DATA, 32'h8765_4321);
    for (int k = 0; k < 40; k++) begin
      wait_cyc(1);
      ok &= (oe_n === 4'hF);
    end
    chk(32'(ok), 32'h1, "link takes pins");
    link_en <= 1'b0;
    // narrower port claims pin 0, the rest stay usable
    claim <= 4'h1;
    ok = 1'b1;
    wr(A_DATA, 32'h8765_4321);
    for (int k = 0; k < 40; k++) begin
      wait_cyc(1);
      ok &= (oe_n[0] === 1'b1);
    end
    chk(32'(ok), 32'h1, "claimed pin released");
    chk(32'(oe_n[3:1]), 32'h0, "unclaimed pins drive");
    chk(32'(pin_out[3:1]), 32'h4, "full width shifted");
    claim <= 4'h0;
    // timed output waits for the counter, stamped at the load
    wr(A_CTRL, 32'h23);
    rd(A_CNT);
    c0 = got + 32'd40;
    wr(A_TIME, c0);
    outq.delete();
    wr(A_DATA, 32'h8765_4321);
    wait_cyc(50);
    chk(32'(outq.size()), 32'h0, "held until time");
    wait_cyc(80);
    chk(32'(outq.size()), 32'h8, "timed slices");
    rd(A_TSTAMP);
    chk(got, c0, "output timestamp");
    // input with strobe qualification, event on completion; the port is
    // parked first so the old output level has left the pin synchronisers
    app_val <= 4'h9;
    wr(A_CTRL, 32'h00);
    wait_cyc(2);
    wr(A_CTRL, 32'h41);
    n_ev = 0;
    wait_cyc(60);
    chk(32'(n_ev), 32'h1, "word event");
    rd(A_STAT);
    chk(32'(got[ST_RX_FULL]), 32'h1, "rx full");
    rd(A_DATA);
    chk(got, 32'h9999_9999, "input word");
    in_strb <= 1'b0;
    wait_cyc(4);
    rd(A_DATA);
    wait_cyc(60);
    rd(A_STAT);
    chk(32'(got[ST_RX_FULL]), 32'h0, "no sample without strobe");
    in_strb <= 1'b1;
    // conditional wait signals an event once met
    wr(A_CTRL, 32'h00);
    rd(A_DATA);
    app_val <= 4'h0;
    wr(A_COND, 32'h6);
    wr(A_CTRL, 32'h09);
    n_ev = 0;
    wait_cyc(30);
    chk(32'(n_ev), 32'h0, "condition not met");
    app_val <= 4'h6;
    wait_cyc(12);
    chk(32'(n_ev), 32'h1, "condition event");
    // not-equal condition fires once the pins move off the value
    wr(A_CTRL, 32'h00);
    wr(A_CTRL, 32'h11);
    n_ev = 0;
    wait_cyc(30);
    chk(32'(n_ev), 32'h0, "neq condition held");
    app_val <= 4'h5;
    wait_cyc(12);
    chk(32'(n_ev), 32'h1, "neq condition event");
    // clock block fed from the board clock
    wr(A_CTRL, 32'h00);
    wr(A_CB1, 32'h100);
    wr(A_CTRL, 32'h81);
    rd(A_CNT);
    c0 = got;
    wait_cyc(20);
    rd(A_CNT);
    chk(got, c0, "stopped board clock");
    ext_run <= 1'b1;
    wait_cyc(40);
    rd(A_CNT);
    chk(32'(got > c0), 32'h1, "board clock ticks");
    ext_run <= 1'b0;
    wr(A_CTRL, 32'h381);
    rd(A_CNT);
    c0 = got;
    wait_cyc(20);
    rd(A_CNT);
    chk(got, c0, "no such clock block");
    test_done();
  end
endmodule : tb_timed_serdes_io_port
